/* File: hdl/tam_target.sv */
// Two-wire target: address match, status flags, data shift register, Wishbone slave.
// Assumes an external open-drain resolver joins the scl/sda enables with the bus wires.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module tam_target (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_we_i,
	input  wire logic [3:0] wb_adr_i,
	input  wire logic [7:0] wb_dat_i,
	input  wire logic       wb_sel_i,
	output logic      [7:0] wb_dat_o,
	output logic            wb_ack_o,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_o,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o
);
	typedef enum logic [2:0] {
		TAM_IDLE, TAM_ADDR, TAM_ADDR_ACK, TAM_RX, TAM_TX, TAM_ACK_OUT, TAM_ACK_IN, TAM_HOLD
	} tam_state_e;

	tam_pkg::tam_line_s line;
	tam_state_e         state_reg;
	logic [7:0]         addr_reg;
	logic [7:0]         mask_reg;
	logic [7:0]         shift_reg;
	logic [3:0]         bit_cnt_reg;
	logic               ack_sel_reg;
	logic               data_flag_reg;
	logic               addr_flag_reg;
	logic               cause_reg;
	logic               dir_reg;
	logic               rxack_reg;
	logic               ack_pending_reg;
	logic               sda_low_reg;
	logic               hold_low_reg;
	logic               wb_ack_reg;
	logic [7:0]         rd_data;
	logic               bus_req;
	logic               wr_ctrl;
	logic               wr_status;
	logic               data_access;
	logic               addr_hit;
	logic               holding;
	logic               shifting;
	logic               cmd_valid;
	logic               addr_done;
	logic               data_set;

	tam_line_sync u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.scl_i  (scl_i),
		.sda_i  (sda_i),
		.line_o (line)
	);

	// Compares seven received bits, honouring mask or second address.
	function automatic logic addr_match(input logic [6:0] rx, input logic [7:0] a,
		input logic [7:0] m);
		logic hit;
		hit = 1'b0;
		if (m[0])
			hit = (rx == a[7:1]) || (rx == m[7:1]);
		else
			hit = ((rx ^ a[7:1]) & ~m[7:1]) == 7'h00;
		return hit;
	endfunction

	// A 10-bit first byte is matched like any 7-bit value: software loads 11110aa.
	assign addr_hit = addr_match(shift_reg[7:1], addr_reg, mask_reg) ||
		(addr_reg[0] && shift_reg[7:1] == tam_pkg::GCALL_ADDR && !shift_reg[0]);

	assign holding     = state_reg == TAM_HOLD;
	assign shifting    = state_reg == TAM_RX || state_reg == TAM_TX;
	assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
	assign data_access = bus_req && wb_adr_i == tam_pkg::OFF_DATA;
	assign wr_ctrl     = bus_req && wb_we_i && wb_sel_i && wb_adr_i == tam_pkg::OFF_CTRL;
	assign wr_status   = bus_req && wb_we_i && wb_sel_i && wb_adr_i == tam_pkg::OFF_STATUS;
	assign cmd_valid   = wr_ctrl && wb_dat_i[1];
	// The address byte is complete on the falling edge that follows its eighth bit.
	assign addr_done   = state_reg == TAM_ADDR && line.scl_fall &&
		bit_cnt_reg == 4'(tam_pkg::BYTE_BITS);
	assign data_set    = (state_reg == TAM_RX && line.scl_fall &&
		bit_cnt_reg == 4'(tam_pkg::BYTE_BITS)) ||
		(state_reg == TAM_ACK_OUT && line.scl_fall && dir_reg) ||
		(state_reg == TAM_ACK_IN && line.scl_fall);

	always_comb begin
		rd_data = tam_pkg::RST_BYTE;
		case (wb_adr_i)
			tam_pkg::OFF_CTRL: rd_data[tam_pkg::CT_ACK_SEL] = ack_sel_reg;
			tam_pkg::OFF_STATUS: begin
				rd_data[tam_pkg::ST_DATA_FLAG] = data_flag_reg;
				rd_data[tam_pkg::ST_ADDR_FLAG] = addr_flag_reg;
				rd_data[tam_pkg::ST_HOLD]      = holding;
				rd_data[tam_pkg::ST_RXACK]     = rxack_reg;
				rd_data[tam_pkg::ST_DIR]       = dir_reg;
				rd_data[tam_pkg::ST_CAUSE]     = cause_reg;
			end
			tam_pkg::OFF_ADDR: rd_data = addr_reg;
			tam_pkg::OFF_DATA: rd_data = shift_reg;
			tam_pkg::OFF_MASK: rd_data = mask_reg;
			default: rd_data = tam_pkg::RST_BYTE;
		endcase
	end

	// Every access, mapped or not, is acknowledged one cycle after it is seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_reg <= 1'b0;
			wb_dat_o   <= tam_pkg::RST_BYTE;
		end else begin
			wb_ack_reg <= bus_req;
			if (bus_req)
				wb_dat_o <= rd_data;
		end
	end
	assign wb_ack_o = wb_ack_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_reg    <= tam_pkg::RST_BYTE;
			mask_reg    <= tam_pkg::RST_BYTE;
			ack_sel_reg <= 1'b0;
		end else if (bus_req && wb_we_i && wb_sel_i) begin
			if (wb_adr_i == tam_pkg::OFF_ADDR)
				addr_reg <= wb_dat_i;
			if (wb_adr_i == tam_pkg::OFF_MASK)
				mask_reg <= wb_dat_i;
			if (wb_adr_i == tam_pkg::OFF_CTRL)
				ack_sel_reg <= wb_dat_i[tam_pkg::CT_ACK_SEL];
		end
	end

	// Direction and cause are hardware-owned; status writes touch only the flags.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_reg   <= 1'b0;
			cause_reg <= 1'b0;
		end else if (addr_done && addr_hit) begin
			dir_reg   <= shift_reg[0];
			cause_reg <= 1'b1;
		end else if (line.stop && state_reg != TAM_IDLE) begin
			cause_reg <= 1'b0;
		end
	end

	// Hardware sets win over any clear in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_flag_reg <= 1'b0;
			data_flag_reg <= 1'b0;
		end else begin
			if ((addr_done && addr_hit) || (line.stop && state_reg != TAM_IDLE))
				addr_flag_reg <= 1'b1;
			else if ((holding && (data_access || cmd_valid)) ||
				(wr_status && wb_dat_i[tam_pkg::ST_ADDR_FLAG]))
				addr_flag_reg <= 1'b0;
			if (data_set)
				data_flag_reg <= 1'b1;
			else if (data_access || cmd_valid ||
				(wr_status && wb_dat_i[tam_pkg::ST_DATA_FLAG]))
				data_flag_reg <= 1'b0;
		end
	end

	// Link sequencer: shift register, ack timing and clock stretching.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg       <= TAM_IDLE;
			shift_reg       <= tam_pkg::RST_BYTE;
			bit_cnt_reg     <= 4'h0;
			rxack_reg       <= 1'b0;
			ack_pending_reg <= 1'b0;
			sda_low_reg     <= 1'b0;
			hold_low_reg    <= 1'b0;
		end else if (line.start) begin
			state_reg    <= TAM_ADDR;
			bit_cnt_reg  <= 4'h0;
			sda_low_reg  <= 1'b0;
			hold_low_reg <= 1'b0;
		end else if (line.stop) begin
			state_reg    <= TAM_IDLE;
			sda_low_reg  <= 1'b0;
			hold_low_reg <= 1'b0;
		end else begin
			case (state_reg)
				TAM_IDLE: sda_low_reg <= 1'b0;
				TAM_ADDR, TAM_RX: begin
					if (line.scl_rise) begin
						shift_reg   <= {shift_reg[6:0], line.sda};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					if (line.scl_fall && bit_cnt_reg == 4'(tam_pkg::BYTE_BITS)) begin
						hold_low_reg <= 1'b1;
						state_reg    <= TAM_HOLD;
						if (state_reg == TAM_ADDR)
							state_reg <= addr_hit ? TAM_HOLD : TAM_IDLE;
						if (state_reg == TAM_ADDR && !addr_hit)
							hold_low_reg <= 1'b0;
						ack_pending_reg <= 1'b1;
					end
				end
				TAM_TX: begin
					if (line.scl_fall) begin
						shift_reg   <= {shift_reg[6:0], 1'b1};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						sda_low_reg <= ~shift_reg[6];
						if (bit_cnt_reg == 4'(tam_pkg::BYTE_BITS - 1)) begin
							sda_low_reg <= 1'b0;
							state_reg   <= TAM_ACK_IN;
						end
					end
				end
				TAM_ACK_IN: begin
					if (line.scl_rise)
						rxack_reg <= line.sda;
					if (line.scl_fall) begin
						state_reg    <= line.sda ? TAM_ADDR_ACK : TAM_HOLD;
						hold_low_reg <= ~line.sda;
						ack_pending_reg <= 1'b0;
					end
				end
				TAM_ACK_OUT: begin
					if (line.scl_fall) begin
						sda_low_reg <= 1'b0;
						bit_cnt_reg <= 4'h0;
						if (dir_reg) begin
							state_reg    <= TAM_HOLD;
							hold_low_reg <= 1'b1;
						end else begin
							state_reg <= TAM_RX;
						end
					end
				end
				// After a refused byte the target waits for the frame to close, so a stop
				// still raises the address-or-stop flag.
				TAM_ADDR_ACK: sda_low_reg <= 1'b0;
				TAM_HOLD: begin
					// Writes to the shift register are only honoured here.
					if (bus_req && wb_we_i && wb_sel_i && wb_adr_i == tam_pkg::OFF_DATA)
						shift_reg <= wb_dat_i;
					if (data_access || cmd_valid) begin
						hold_low_reg <= 1'b0;
						bit_cnt_reg  <= 4'h0;
						if (ack_pending_reg) begin
							sda_low_reg     <= ~ack_sel_reg;
							ack_pending_reg <= 1'b0;
							state_reg       <= TAM_ACK_OUT;
						end else if (dir_reg && !(cmd_valid &&
							wb_dat_i[1:0] == tam_pkg::CMD_COMPLETE)) begin
							state_reg   <= TAM_TX;
							sda_low_reg <= bus_req && wb_we_i && wb_adr_i == tam_pkg::OFF_DATA ?
								~wb_dat_i[7] : ~shift_reg[7];
						end else begin
							state_reg <= TAM_IDLE;
						end
					end
				end
				default: state_reg <= TAM_IDLE;
			endcase
		end
	end

	assign scl_o    = 1'b0;
	assign scl_oe_o = hold_low_reg;
	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_low_reg;

	hold_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(holding) |-> (addr_flag_reg || data_flag_reg))
		else $error("hold flag without cause");
	dir_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_status |=> dir_reg == $past(dir_reg) || $past(addr_done))
		else $error("direction changed by write");
	stop_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(line.stop && state_reg != TAM_IDLE && !line.start) |=> addr_flag_reg && !cause_reg)
		else $error("stop did not set flag");
	data_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(data_access && !data_set) |=> !data_flag_reg)
		else $error("data flag not cleared");
	shift_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(shifting && data_access && wb_we_i && !line.scl_rise && !line.scl_fall &&
		!line.start && !line.stop) |=> shift_reg == $past(shift_reg))
		else $error("write during shift");
	resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(holding && data_access && !line.start && !line.stop) |=> !scl_oe_o)
		else $error("hold not released");
	ack_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(holding && ack_pending_reg && data_access && !line.start && !line.stop) |=>
		sda_oe_o == !ack_sel_reg)
		else $error("wrong ack response");
	gcall_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(addr_done && shift_reg == 8'h00 && !addr_reg[0] && mask_reg == 8'h00 &&
		addr_reg[7:1] != 7'h00) |=> state_reg == TAM_IDLE && !hold_low_reg)
		else $error("general call matched while off");
endmodule

/* File: hdl/tam_pkg.sv */
// Constants, register map and carrier types for the two-wire target address/data block.
// Assumes a 10 MHz peripheral clock and a classic Wishbone register bus.
package tam_pkg;
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h1;
	localparam logic [3:0] OFF_ADDR   = 4'hC;
	localparam logic [3:0] OFF_DATA   = 4'hD;
	localparam logic [3:0] OFF_MASK   = 4'hE;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam int         BYTE_BITS  = 8;
	localparam logic [6:0] GCALL_ADDR = 7'h00;
	localparam int         ST_DATA_FLAG = 7;
	localparam int         ST_ADDR_FLAG = 6;
	localparam int         ST_HOLD      = 5;
	localparam int         ST_RXACK     = 4;
	localparam int         ST_DIR       = 1;
	localparam int         ST_CAUSE     = 0;
	localparam int         CT_ACK_SEL   = 2;
	localparam logic [1:0] CMD_COMPLETE = 2'h2;
	localparam logic [1:0] CMD_RESPONSE = 2'h3;
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
		logic scl_fall;
		logic sda;
	} tam_line_s;
endpackage

/* File: hdl/tam_line_sync.sv */
// Two-flop synchronisers and start/stop/edge detection for the two-wire pins.
// Assumes raw pin levels that are asynchronous to clk_i.
`timescale 1ns/1ps
module tam_line_sync (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output tam_pkg::tam_line_s line_o
);
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_last_reg;
	logic       sda_last_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_last_reg <= 1'b1;
			sda_last_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			scl_last_reg <= scl_sync_reg[1];
			sda_last_reg <= sda_sync_reg[1];
		end
	end

	always_comb begin
		line_o.sda      = sda_sync_reg[1];
		line_o.scl_rise = scl_sync_reg[1] & ~scl_last_reg;
		line_o.scl_fall = ~scl_sync_reg[1] & scl_last_reg;
		line_o.start    = scl_sync_reg[1] & scl_last_reg & sda_last_reg & ~sda_sync_reg[1];
		line_o.stop     = scl_sync_reg[1] & scl_last_reg & ~sda_last_reg & sda_sync_reg[1];
	end
endmodule

/* File: bench/tam_master_model.sv */
// Behavioural two-wire bus controller that drives the target in the bench.
// Assumes open-drain lines with pull-ups resolved by the bench; clk_i paces each bit.
`timescale 1ns/1ps
module tam_master_model (
	input  wire logic clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_low_o,
	output logic      sda_low_o
);
	// A quarter step of a bit, counted in 100 ns clock cycles; with the extra scl_up cycle a bit lasts at least 900 ns.
	localparam int QTR = 2;

	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end

	task automatic qtr();
		repeat (QTR) @(posedge clk_i);
	endtask

	// The target may stretch the clock, so each high phase waits for the wire itself.
	task automatic scl_up();
		scl_low_o <= 1'b0;
		@(posedge clk_i);
		while (scl_i !== 1'b1) @(posedge clk_i);
	endtask

	task automatic start_c();
		qtr();
		sda_low_o <= 1'b1;
		qtr();
		scl_low_o <= 1'b1;
		qtr();
	endtask

	task automatic bit_x(input logic b, output logic r);
		sda_low_o <= ~b;
		qtr();
		scl_up();
		qtr();
		r = sda_i;
		qtr();
		scl_low_o <= 1'b1;
		qtr();
	endtask

	// Sends d most significant bit first, then clocks the ninth bit with ack_bit released or low.
	task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] rd,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], rd[i]);
		bit_x(ack_bit, ack);
	endtask

	task automatic stop_c();
		sda_low_o <= 1'b1;
		qtr();
		scl_up();
		qtr();
		sda_low_o <= 1'b0;
		qtr();
	endtask
endmodule

/* File: bench/tam_target_test.sv */
// Self-checking bench for the two-wire target: Wishbone register tasks and bus transfers.
// Assumes the controller model beside it and pull-up resolution of both open-drain wires.
`timescale 1ns/1ps
module tam_target_test;
	localparam logic [3:0]  OFFS [5] = '{tam_pkg::OFF_ADDR, tam_pkg::OFF_DATA,
		tam_pkg::OFF_MASK, tam_pkg::OFF_STATUS, 4'h5};
	// Each entry is mask register, address register, address byte, expected match.
	localparam logic [24:0] CASES [8] = '{{8'h00, 8'hA0, 8'hA2, 1'b0},
		{8'h02, 8'hA0, 8'hA2, 1'b1}, {8'h67, 8'hA0, 8'h66, 1'b1}, {8'h67, 8'hA0, 8'hA2, 1'b0},
		{8'h00, 8'hA0, 8'h00, 1'b0}, {8'h00, 8'hA1, 8'h00, 1'b1}, {8'h00, 8'hA1, 8'h01, 1'b0},
		{8'h00, 8'hF4, 8'hF4, 1'b1}};
	logic       clk_i;
	logic       rst_i;
	logic       wb_cyc;
	logic       wb_stb;
	logic       wb_we;
	logic [3:0] wb_adr;
	logic [7:0] wb_wdat;
	logic [7:0] wb_rdat;
	logic       wb_ack;
	logic       scl_oe;
	logic       sda_oe;
	logic       m_scl_low;
	logic       m_sda_low;
	logic [7:0] s;
	logic [7:0] rd;
	logic       ack;
	int         error_cnt = 0;
	int         total_checks = 0;
	wire        scl_w = ~(scl_oe | m_scl_low);
	wire        sda_w = ~(sda_oe | m_sda_low);

	tam_target dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(1'b1),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe));
	tam_master_model m (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl_low),
		.sda_low_o(m_sda_low));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb_xfer(1'b1, a, d, q);
	endtask

	// Polling is bounded so a flag that never rises shows up as a mismatch, not a hang.
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do begin
			wb_xfer(1'b0, tam_pkg::OFF_STATUS, 8'h00, s);
			n++;
		end while (s[b] !== 1'b1 && n < 300);
		chk({7'h00, s[b]}, 8'h01);
	endtask

	task automatic addr_phase(input logic [7:0] ab, input logic hit);
		m.start_c();
		fork
			m.xfer(ab, 1'b1, rd, ack);
			if (hit) begin
				wait_flag(tam_pkg::ST_ADDR_FLAG);
				chk(s & 8'h63, 8'h61 | {6'h00, ab[0], 1'b0});
				wr(tam_pkg::OFF_CTRL, {6'h00, tam_pkg::CMD_RESPONSE});
			end
		join
		chk({7'h00, ack}, {7'h00, ~hit});
	endtask

	task automatic end_txn(input logic hit);
		m.stop_c();
		if (hit) begin
			wait_flag(tam_pkg::ST_ADDR_FLAG);
			chk(s & 8'h41, 8'h40);
		end
		wr(tam_pkg::OFF_STATUS, 8'hC0);
	endtask

	task automatic wrap_up();
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		wrap_up();
	end

	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_wdat = 8'h00;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (OFFS[i]) begin
			wb_xfer(1'b0, OFFS[i], 8'h00, s);
			chk(s, 8'h00);
		end
		wr(tam_pkg::OFF_ADDR, 8'hA0);
		wb_xfer(1'b0, tam_pkg::OFF_ADDR, 8'h00, s);
		chk(s, 8'hA0);
		wr(tam_pkg::OFF_DATA, 8'h55);
		wb_xfer(1'b0, tam_pkg::OFF_DATA, 8'h00, s);
		chk(s, 8'h00);
		addr_phase(8'hA0, 1'b1);
		fork
			m.xfer(8'hC3, 1'b1, rd, ack);
			begin
				wait_flag(tam_pkg::ST_DATA_FLAG);
				wb_xfer(1'b0, tam_pkg::OFF_DATA, 8'h00, s);
				chk(s, 8'hC3);
			end
		join
		chk({7'h00, ack}, 8'h00);
		// The write lands mid-byte, while the shift register is busy, and must be dropped.
		fork
			m.xfer(8'h3C, 1'b1, rd, ack);
			begin
				repeat (20) @(posedge clk_i);
				wr(tam_pkg::OFF_DATA, 8'hFF);
				wait_flag(tam_pkg::ST_DATA_FLAG);
				wr(tam_pkg::OFF_CTRL, 8'h04);
				wb_xfer(1'b0, tam_pkg::OFF_DATA, 8'h00, s);
				chk(s, 8'h3C);
			end
		join
		chk({7'h00, ack}, 8'h01);
		wr(tam_pkg::OFF_CTRL, 8'h00);
		end_txn(1'b1);
		foreach (CASES[i]) begin
			wr(tam_pkg::OFF_MASK, CASES[i][24:17]);
			wr(tam_pkg::OFF_ADDR, CASES[i][16:9]);
			addr_phase(CASES[i][8:1], CASES[i][0]);
			end_txn(CASES[i][0]);
		end
		wr(tam_pkg::OFF_ADDR, 8'hA0);
		addr_phase(8'hA1, 1'b1);
		wait_flag(tam_pkg::ST_DATA_FLAG);
		wr(tam_pkg::OFF_STATUS, 8'h00);
		wb_xfer(1'b0, tam_pkg::OFF_STATUS, 8'h00, s);
		chk(s & 8'h02, 8'h02);
		wr(tam_pkg::OFF_DATA, 8'hA5);
		m.xfer(8'hFF, 1'b1, rd, ack);
		chk(rd, 8'hA5);
		wait_flag(tam_pkg::ST_DATA_FLAG);
		wr(tam_pkg::OFF_CTRL, {6'h00, tam_pkg::CMD_COMPLETE});
		end_txn(1'b1);
		wrap_up();
	end
endmodule
